// [common/sms_regs.vh]
// constants for the superframe mode selector
`ifndef SMS_REGS_VH
`define SMS_REGS_VH

// ----------------------------------------
// mode indicator codes
// ----------------------------------------
`define SMS_MODE_ACELP 2'h0
`define SMS_MODE_SHORT 2'h1
`define SMS_MODE_MEDIUM 2'h2
`define SMS_MODE_LONG 2'h3

// ----------------------------------------
// trial sequencing
// ----------------------------------------
`define SMS_TRIAL_W 4
`define SMS_TRIAL_FIRST 4'h1
`define SMS_TRIAL_LAST 4'hB
`define SMS_TRIAL_PAIR0 4'h5
`define SMS_TRIAL_PAIR1 4'hA

// ----------------------------------------
// quality figures and block sizes
// ----------------------------------------
`define SMS_SNR_W 16
`define SMS_ACC_W 20
`define SMS_SUBFRAME_SAMPLES 64
`define SMS_SF_SHORT 5'h04
`define SMS_SF_MEDIUM 5'h08
`define SMS_SF_LONG 5'h10
`define SMS_SHIFT_SHORT 2'h2
`define SMS_SHIFT_MEDIUM 2'h3
`define SMS_SHIFT_LONG 3'h4

`endif

// [rtl/sms_quality_avg.v]
// averages per-subframe quality figures over one trial block
`timescale 1ns/1ps
`include "sms_regs.vh"

module sms_quality_avg (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // control
  input wire clear,
  input wire [4:0] subframe_count,
  // per-subframe quality from trial encoder
  input wire seg_valid,
  input wire signed [`SMS_SNR_W-1:0] segment_quality_ratio,
  // result
  output wire signed [`SMS_SNR_W-1:0] avg_quality,
  output wire avg_done
);

  // ----------------------------------------
  // accumulation
  // ----------------------------------------
  reg signed [`SMS_ACC_W-1:0] acc_q;
  reg [4:0] cnt_q;
  reg signed [`SMS_ACC_W-1:0] sh;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acc_q <= {`SMS_ACC_W{1'b0}};
      cnt_q <= 5'h00;
    end else if (clear) begin
      acc_q <= {`SMS_ACC_W{1'b0}};
      cnt_q <= 5'h00;
    end else if (seg_valid && !avg_done) begin
      acc_q <= acc_q + {{(`SMS_ACC_W-`SMS_SNR_W){segment_quality_ratio[`SMS_SNR_W-1]}},
                        segment_quality_ratio};
      cnt_q <= cnt_q + 5'h01;
    end
  end

  assign avg_done = (cnt_q == subframe_count) && (subframe_count != 5'h00);

  // divide by 4, 8 or 16 subframes; counts are powers of two so a shift is exact
  always @* begin
    if (subframe_count == `SMS_SF_LONG)
      sh = acc_q >>> `SMS_SHIFT_LONG;
    else if (subframe_count == `SMS_SF_MEDIUM)
      sh = acc_q >>> `SMS_SHIFT_MEDIUM;
    else
      sh = acc_q >>> `SMS_SHIFT_SHORT;
  end

  assign avg_quality = sh[`SMS_SNR_W-1:0];

endmodule // sms_quality_avg

// [rtl/sms_selector.v]
// closed-loop superframe mode selector
`timescale 1ns/1ps
`include "sms_regs.vh"

module sms_selector (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // superframe control
  input wire sf_start,
  output wire sf_busy,
  output reg sf_done,
  // trial request to encoders
  output reg trial_req,
  output reg [3:0] trial_num,
  output reg [3:0] trial_frames,
  output reg [1:0] trial_mode,
  output reg [4:0] subframe_count,
  // per-subframe quality answers
  input wire seg_valid,
  input wire signed [`SMS_SNR_W-1:0] segment_quality_ratio,
  // committed modes, one per packet
  output reg [1:0] first_quarter_frame,
  output reg [1:0] second_quarter_frame,
  output reg [1:0] third_quarter_frame,
  output reg [1:0] fourth_quarter_frame,
  output reg quad_legal
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_REQ = 2'h1;
  localparam ST_WAIT = 2'h2;
  localparam ST_DECIDE = 2'h3;

  reg [1:0] state_q, state_d;
  reg [3:0] trial_q, trial_d;
  reg [1:0] m0_q, m1_q, m2_q, m3_q;
  reg [1:0] m0_d, m1_d, m2_d, m3_d;
  reg signed [`SMS_SNR_W-1:0] q0_q, q1_q, q2_q, q3_q;
  reg signed [`SMS_SNR_W-1:0] q0_d, q1_d, q2_d, q3_d;
  reg signed [`SMS_SNR_W-1:0] half0_q, half1_q, half0_d, half1_d;
  reg signed [`SMS_SNR_W-1:0] acelp_q, acelp_d;

  wire signed [`SMS_SNR_W-1:0] avg_quality;
  wire avg_done;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // mean of two averages; equal-length halves so plain mean equals block average
  function signed [`SMS_SNR_W-1:0] mean2;
    input signed [`SMS_SNR_W-1:0] a;
    input signed [`SMS_SNR_W-1:0] b;
    reg signed [`SMS_SNR_W:0] s;
    begin
      s = {a[`SMS_SNR_W-1], a} + {b[`SMS_SNR_W-1], b};
      mean2 = s[`SMS_SNR_W:1];
    end
  endfunction

  // legality of a quadruplet
  function legal_quad;
    input [1:0] a;
    input [1:0] b;
    input [1:0] c;
    input [1:0] d;
    reg all_long;
    reg any_long;
    begin
      all_long = (a == `SMS_MODE_LONG) && (b == `SMS_MODE_LONG) &&
                 (c == `SMS_MODE_LONG) && (d == `SMS_MODE_LONG);
      any_long = (a == `SMS_MODE_LONG) || (b == `SMS_MODE_LONG) ||
                 (c == `SMS_MODE_LONG) || (d == `SMS_MODE_LONG);
      legal_quad = all_long ||
        (!any_long &&
         ((a == `SMS_MODE_MEDIUM) == (b == `SMS_MODE_MEDIUM)) &&
         ((c == `SMS_MODE_MEDIUM) == (d == `SMS_MODE_MEDIUM)));
    end
  endfunction

  // ----------------------------------------
  // trial description
  // ----------------------------------------
  // each trial names its frames (bit k for frame k), its mode code and how many
  // subframe figures it averages; grouped trials must get the matching length
  always @* begin
    trial_frames = 4'h0;
    trial_mode = `SMS_MODE_ACELP;
    subframe_count = `SMS_SF_SHORT;
    case (trial_q)
      4'h1: begin trial_frames = 4'h1; trial_mode = `SMS_MODE_ACELP; end
      4'h2: begin trial_frames = 4'h1; trial_mode = `SMS_MODE_SHORT; end
      4'h3: begin trial_frames = 4'h2; trial_mode = `SMS_MODE_ACELP; end
      4'h4: begin trial_frames = 4'h2; trial_mode = `SMS_MODE_SHORT; end
      4'h5: begin
        trial_frames = 4'h3;
        trial_mode = `SMS_MODE_MEDIUM;
        subframe_count = `SMS_SF_MEDIUM;
      end
      4'h6: begin trial_frames = 4'h4; trial_mode = `SMS_MODE_ACELP; end
      4'h7: begin trial_frames = 4'h4; trial_mode = `SMS_MODE_SHORT; end
      4'h8: begin trial_frames = 4'h8; trial_mode = `SMS_MODE_ACELP; end
      4'h9: begin trial_frames = 4'h8; trial_mode = `SMS_MODE_SHORT; end
      4'hA: begin
        trial_frames = 4'hC;
        trial_mode = `SMS_MODE_MEDIUM;
        subframe_count = `SMS_SF_MEDIUM;
      end
      4'hB: begin
        trial_frames = 4'hF;
        trial_mode = `SMS_MODE_LONG;
        subframe_count = `SMS_SF_LONG;
      end
      default: begin
        trial_frames = 4'h0;
      end
    endcase
  end

  // ----------------------------------------
  // quality averaging
  // ----------------------------------------
  sms_quality_avg u_avg (
    .sys_clk(sys_clk),
    .rst(rst),
    .clear(state_q == ST_REQ),
    .subframe_count(subframe_count),
    .seg_valid(seg_valid && (state_q == ST_WAIT)),
    .segment_quality_ratio(segment_quality_ratio),
    .avg_quality(avg_quality),
    .avg_done(avg_done)
  );

  // ----------------------------------------
  // sequencing and decisions
  // ----------------------------------------
  always @* begin
    state_d = state_q;
    trial_d = trial_q;
    m0_d = m0_q;
    m1_d = m1_q;
    m2_d = m2_q;
    m3_d = m3_q;
    q0_d = q0_q;
    q1_d = q1_q;
    q2_d = q2_q;
    q3_d = q3_q;
    half0_d = half0_q;
    half1_d = half1_q;
    acelp_d = acelp_q;
    trial_req = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (sf_start) begin
          state_d = ST_REQ;
          trial_d = `SMS_TRIAL_FIRST;
          m0_d = `SMS_MODE_ACELP;
          m1_d = `SMS_MODE_ACELP;
          m2_d = `SMS_MODE_ACELP;
          m3_d = `SMS_MODE_ACELP;
        end
      end
      ST_REQ: begin
        trial_req = 1'b1;
        state_d = ST_WAIT;
      end
      ST_WAIT: begin
        // next request only once this trial's figures are all in
        trial_req = 1'b1;
        if (avg_done)
          state_d = ST_DECIDE;
      end
      ST_DECIDE: begin
        // strict greater-than keeps the held choice on ties
        case (trial_q)
          4'h1, 4'h6: acelp_d = avg_quality;
          4'h2: begin
            if (avg_quality > acelp_q) begin
              m0_d = `SMS_MODE_SHORT; q0_d = avg_quality;
            end else begin
              m0_d = `SMS_MODE_ACELP; q0_d = acelp_q;
            end
          end
          4'h3, 4'h8: acelp_d = avg_quality;
          4'h4: begin
            if (avg_quality > acelp_q) begin
              m1_d = `SMS_MODE_SHORT; q1_d = avg_quality;
            end else begin
              m1_d = `SMS_MODE_ACELP; q1_d = acelp_q;
            end
          end
          4'h5: begin
            if (avg_quality > mean2(q0_q, q1_q)) begin
              m0_d = `SMS_MODE_MEDIUM; m1_d = `SMS_MODE_MEDIUM;
              half0_d = avg_quality;
            end else begin
              half0_d = mean2(q0_q, q1_q);
            end
          end
          4'h7: begin
            if (avg_quality > acelp_q) begin
              m2_d = `SMS_MODE_SHORT; q2_d = avg_quality;
            end else begin
              m2_d = `SMS_MODE_ACELP; q2_d = acelp_q;
            end
          end
          4'h9: begin
            if (avg_quality > acelp_q) begin
              m3_d = `SMS_MODE_SHORT; q3_d = avg_quality;
            end else begin
              m3_d = `SMS_MODE_ACELP; q3_d = acelp_q;
            end
          end
          4'hA: begin
            if (avg_quality > mean2(q2_q, q3_q)) begin
              m2_d = `SMS_MODE_MEDIUM; m3_d = `SMS_MODE_MEDIUM;
              half1_d = avg_quality;
            end else begin
              half1_d = mean2(q2_q, q3_q);
            end
          end
          4'hB: begin
            if (avg_quality > mean2(half0_q, half1_q)) begin
              m0_d = `SMS_MODE_LONG;
              m1_d = `SMS_MODE_LONG;
              m2_d = `SMS_MODE_LONG;
              m3_d = `SMS_MODE_LONG;
            end
          end
          default: begin
            acelp_d = acelp_q;
          end
        endcase
        // the last decide goes idle; the commit block samples the final set in this cycle
        if (trial_q == `SMS_TRIAL_LAST) begin
          state_d = ST_IDLE;
        end else begin
          trial_d = trial_q + 4'h1;
          state_d = ST_REQ;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      trial_q <= 4'h0;
      m0_q <= `SMS_MODE_ACELP;
      m1_q <= `SMS_MODE_ACELP;
      m2_q <= `SMS_MODE_ACELP;
      m3_q <= `SMS_MODE_ACELP;
      q0_q <= {`SMS_SNR_W{1'b0}};
      q1_q <= {`SMS_SNR_W{1'b0}};
      q2_q <= {`SMS_SNR_W{1'b0}};
      q3_q <= {`SMS_SNR_W{1'b0}};
      half0_q <= {`SMS_SNR_W{1'b0}};
      half1_q <= {`SMS_SNR_W{1'b0}};
      acelp_q <= {`SMS_SNR_W{1'b0}};
    end else begin
      state_q <= state_d;
      trial_q <= trial_d;
      m0_q <= m0_d;
      m1_q <= m1_d;
      m2_q <= m2_d;
      m3_q <= m3_d;
      q0_q <= q0_d;
      q1_q <= q1_d;
      q2_q <= q2_d;
      q3_q <= q3_d;
      half0_q <= half0_d;
      half1_q <= half1_d;
      acelp_q <= acelp_d;
    end
  end

  // ----------------------------------------
  // commit
  // ----------------------------------------
  // legality is judged on the set being committed, not on the one still held
  wire quad_ok;
  assign quad_ok = legal_quad(m0_d, m1_d, m2_d, m3_d);

  // outputs move only at the end of trial 11, so packets never see provisional modes
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      first_quarter_frame <= `SMS_MODE_ACELP;
      second_quarter_frame <= `SMS_MODE_ACELP;
      third_quarter_frame <= `SMS_MODE_ACELP;
      fourth_quarter_frame <= `SMS_MODE_ACELP;
      quad_legal <= 1'b1;
      sf_done <= 1'b0;
    end else begin
      sf_done <= 1'b0;
      if (state_q == ST_DECIDE && trial_q == `SMS_TRIAL_LAST) begin
        first_quarter_frame <= m0_d;
        second_quarter_frame <= m1_d;
        third_quarter_frame <= m2_d;
        fourth_quarter_frame <= m3_d;
        quad_legal <= quad_ok;
        sf_done <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // trial number and busy
  // ----------------------------------------
  // trial_num follows trial_q, so it stays steady for the whole request and decide
  always @(posedge sys_clk or posedge rst) begin
    if (rst)
      trial_num <= 4'h0;
    else
      trial_num <= trial_d;
  end

  assign sf_busy = (state_q != ST_IDLE);

endmodule // sms_selector

// [dv/sms_selector_chk.sv]
// port checker for the superframe mode selector
`timescale 1ns/1ps
module sms_selector_chk (
  // clock and reset
  input logic sys_clk,
  input logic rst,
  // superframe and trial control
  input logic sf_start,
  input logic sf_busy,
  input logic sf_done,
  input logic trial_req,
  input logic [3:0] trial_num,
  input logic [3:0] trial_frames,
  input logic [1:0] trial_mode,
  input logic [4:0] subframe_count,
  input logic seg_valid,
  input logic signed [15:0] segment_quality_ratio,
  // committed modes
  input logic [1:0] first_quarter_frame,
  input logic [1:0] second_quarter_frame,
  input logic [1:0] third_quarter_frame,
  input logic [1:0] fourth_quarter_frame,
  input logic quad_legal
);
  logic [7:0] quad;
  assign quad = {first_quarter_frame, second_quarter_frame, third_quarter_frame,
                 fourth_quarter_frame};
  function automatic logic [1:0] mode_of(input logic [3:0] n);
    case (n)
      4'h1, 4'h3, 4'h6, 4'h8: return 2'h0;
      4'h5, 4'hA: return 2'h2;
      4'hB: return 2'h3;
      default: return 2'h1;
    endcase
  endfunction
  function automatic logic [3:0] frames_of(input logic [3:0] n);
    case (n)
      4'h1, 4'h2: return 4'h1;
      4'h3, 4'h4: return 4'h2;
      4'h5: return 4'h3;
      4'h6, 4'h7: return 4'h4;
      4'h8, 4'h9: return 4'h8;
      4'hA: return 4'hC;
      default: return 4'hF;
    endcase
  endfunction
  // a pair half is legal only as both medium or neither medium
  function automatic logic legal(input logic [7:0] m);
    if (m == 8'hFF) return 1'b1;
    if (m[7:6] == 2'h3 || m[5:4] == 2'h3 || m[3:2] == 2'h3 || m[1:0] == 2'h3) return 1'b0;
    return ((m[7:6] == 2'h2) == (m[5:4] == 2'h2)) && ((m[3:2] == 2'h2) == (m[1:0] == 2'h2));
  endfunction
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence seq_start;
    sf_start && !sf_busy;
  endsequence
  sequence seq_first_req;
    trial_req && trial_num == 4'h1;
  endsequence
  chk_start_req: assert property (seq_start |=> seq_first_req)
    else $error("trial 1 not requested after start");
  chk_trial_next: assert property ($fell(trial_req) && $past(trial_num) != 4'hB
    |=> trial_req && trial_num == $past(trial_num, 2) + 4'h1) else $error("trial order");
  chk_done_last: assert property ($fell(trial_req) && $past(trial_num) == 4'hB
    |=> sf_done && !sf_busy) else $error("no commit after last trial");
  chk_mode_map: assert property (trial_req |-> trial_mode == mode_of(trial_num))
    else $error("trial mode wrong");
  chk_frame_map: assert property (trial_req |-> trial_frames == frames_of(trial_num))
    else $error("trial frames wrong");
  chk_count_map: assert property (trial_req |-> subframe_count ==
    (trial_mode == 2'h3 ? 5'h10 : trial_mode == 2'h2 ? 5'h08 : 5'h04)) else $error("count wrong");
  chk_pair_first: assert property (first_quarter_frame == 2'h2
    |-> second_quarter_frame == 2'h2) else $error("first pair split");
  chk_pair_second: assert property (third_quarter_frame == 2'h2
    |-> fourth_quarter_frame == 2'h2) else $error("second pair split");
  chk_long_all: assert property (first_quarter_frame == 2'h3 || fourth_quarter_frame == 2'h3
    |-> quad == 8'hFF) else $error("long mode mixed");
  chk_legal_flag: assert property (quad_legal == legal(quad) && quad_legal)
    else $error("illegal quadruplet");
  chk_commit_only: assert property (!sf_done |-> $stable(quad))
    else $error("modes moved without commit");
  chk_done_pulse: assert property (sf_done |=> !sf_done)
    else $error("done longer than one cycle");
endmodule // sms_selector_chk

bind sms_selector sms_selector_chk u_sms_selector_chk (.sys_clk(sys_clk), .rst(rst),
  .sf_start(sf_start), .sf_busy(sf_busy), .sf_done(sf_done), .trial_req(trial_req),
  .trial_num(trial_num), .trial_frames(trial_frames), .trial_mode(trial_mode),
  .subframe_count(subframe_count), .seg_valid(seg_valid),
  .segment_quality_ratio(segment_quality_ratio), .first_quarter_frame(first_quarter_frame),
  .second_quarter_frame(second_quarter_frame), .third_quarter_frame(third_quarter_frame),
  .fourth_quarter_frame(fourth_quarter_frame), .quad_legal(quad_legal));

// [dv/sms_enc_model.sv]
// trial encoder model answering each trial with per-subframe figures
`timescale 1ns/1ps
module sms_enc_model (
  // clock and reset
  input logic sys_clk,
  input logic rst,
  // trial request
  input logic trial_req,
  input logic [3:0] trial_num,
  input logic [4:0] subframe_count,
  // bench controls
  input logic slow,
  input logic [15:0] fig_tab [1:11],
  // quality answers
  output logic seg_valid,
  output logic signed [15:0] segment_quality_ratio
);
  logic seen_q;
  logic gap_q;
  logic [4:0] sent_q;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      seen_q <= 1'b0;
      gap_q <= 1'b0;
      sent_q <= 5'h00;
      seg_valid <= 1'b0;
      segment_quality_ratio <= 16'h0000;
    end else begin
      seg_valid <= 1'b0;
      // idle figure lines toggle so a stale value never passes as fresh
      segment_quality_ratio <= ~segment_quality_ratio;
      seen_q <= trial_req;
      // the request cycle itself is skipped, the design clears then
      if (!seen_q || !trial_req) begin
        sent_q <= 5'h00;
        gap_q <= 1'b0;
      end else if (sent_q < subframe_count) begin
        gap_q <= slow & ~gap_q;
        if (!slow || gap_q) begin
          seg_valid <= 1'b1;
          segment_quality_ratio <= fig_tab[trial_num];
          sent_q <= sent_q + 5'h01;
        end
      end
    end
  end
endmodule // sms_enc_model

// [dv/testbench.sv]
// self-checking bench for the superframe mode selector
`timescale 1ns/1ps
module testbench;
  logic sys_clk, rst, sf_start, slow;
  logic [15:0] fig_tab [1:11];
  logic [15:0] lfsr;
  logic [7:0] exp_q [$];
  wire seg_valid, sf_busy, sf_done, trial_req, quad_legal;
  wire signed [15:0] segment_quality_ratio;
  wire [3:0] trial_num, trial_frames;
  wire [1:0] trial_mode, m0, m1, m2, m3;
  wire [4:0] subframe_count;
  int err_count, checked, n, k, tmo;
  int q [1:11];

  sms_selector u_sms_selector (.sys_clk(sys_clk), .rst(rst), .sf_start(sf_start),
    .sf_busy(sf_busy), .sf_done(sf_done), .trial_req(trial_req), .trial_num(trial_num),
    .trial_frames(trial_frames), .trial_mode(trial_mode), .subframe_count(subframe_count),
    .seg_valid(seg_valid), .segment_quality_ratio(segment_quality_ratio),
    .first_quarter_frame(m0), .second_quarter_frame(m1), .third_quarter_frame(m2),
    .fourth_quarter_frame(m3), .quad_legal(quad_legal));
  sms_enc_model u_sms_enc_model (.sys_clk(sys_clk), .rst(rst), .trial_req(trial_req),
    .trial_num(trial_num), .subframe_count(subframe_count), .slow(slow), .fig_tab(fig_tab),
    .seg_valid(seg_valid), .segment_quality_ratio(segment_quality_ratio));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // figures are multiples of 4 so every mean is exact; ties keep the held choice
  function automatic logic [7:0] expect_quad();
    int s0, s1, s2, s3, h, g;
    logic [1:0] e0, e1, e2, e3;
    e0 = (q[2] > q[1]) ? 2'h1 : 2'h0;
    s0 = (q[2] > q[1]) ? q[2] : q[1];
    e1 = (q[4] > q[3]) ? 2'h1 : 2'h0;
    s1 = (q[4] > q[3]) ? q[4] : q[3];
    e2 = (q[7] > q[6]) ? 2'h1 : 2'h0;
    s2 = (q[7] > q[6]) ? q[7] : q[6];
    e3 = (q[9] > q[8]) ? 2'h1 : 2'h0;
    s3 = (q[9] > q[8]) ? q[9] : q[8];
    h = (s0 + s1) >>> 1;
    g = (s2 + s3) >>> 1;
    if (q[5] > h) begin
      {e0, e1} = 4'hA;
      h = q[5];
    end
    if (q[10] > g) begin
      {e2, e3} = 4'hA;
      g = q[10];
    end
    if (q[11] > ((h + g) >>> 1)) return 8'hFF;
    return {e0, e1, e2, e3};
  endfunction

  task cmp_quad(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task close_out;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // start is held three cycles so the busy-time copies must be ignored
  task run_sf;
    int w;
    for (k = 1; k <= 11; k++) fig_tab[k] = q[k][15:0];
    exp_q.push_back(expect_quad());
    sf_start = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 sf_start = 1'b0;
    for (w = 0; w < 3000 && sf_done !== 1'b1; w++) begin
      @(posedge sys_clk);
      #1;
    end
    if (w == 3000) begin
      err_count++;
      $display("MISMATCH %0t no commit", $time);
      tmo = 1;
    end
    @(posedge sys_clk);
    #1;
  endtask

  always @(posedge sys_clk) begin
    if (!rst && sf_done === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_count++;
        $display("MISMATCH %0t commit without start", $time);
      end else begin
        cmp_quad({m0, m1, m2, m3}, exp_q.pop_front());
        cmp_quad({7'h00, quad_legal}, 8'h01);
      end
    end
  end

  initial begin
    rst = 1'b1;
    sf_start = 1'b0;
    slow = 1'b0;
    lfsr = 16'h87F9;
    err_count = 0;
    checked = 0;
    tmo = 0;
    for (k = 1; k <= 11; k++) fig_tab[k] = 16'h0000;
    repeat (16) @(posedge sys_clk);
    #1 rst = 1'b0;
    cmp_quad({m0, m1, m2, m3}, 8'h00);
    cmp_quad({5'h00, sf_busy, trial_req, quad_legal}, 8'h01);
    for (n = 0; n < 30 && tmo == 0; n++) begin
      for (k = 1; k <= 11; k++) begin
        q[k] = 40;
        if (n >= 5) begin
          lfsr = lfsr_next(lfsr);
          q[k] = lfsr[7:0] & 8'hFC;
        end
      end
      case (n)
        1: {q[2], q[4], q[7], q[9]} = {32'd80, 32'd80, 32'd80, 32'd80};
        2: {q[5], q[10]} = {32'd100, 32'd100};
        3: q[11] = 100;
        4: {q[1], q[5], q[9], q[10]} = {32'd80, 32'd60, 32'd80, 32'd100};
        default: ;
      endcase
      slow = (n >= 5) ? lfsr[8] : n[0];
      run_sf();
    end
    close_out();
  end
endmodule // testbench
